// File: logic/stm_defines.svh
// Register offsets, field positions, reset values and timing counts
`ifndef STM_DEFINES_SVH
`define STM_DEFINES_SVH

// ************************************************************
// Register byte addresses (one aligned word each)
// ************************************************************
`define STM_OFF_CONTROL0     5'h00
`define STM_OFF_CONTROL1     5'h04
`define STM_OFF_COUNT_LOW    5'h08
`define STM_OFF_COUNT_HIGH   5'h0C
`define STM_OFF_CMPA_LOW     5'h10
`define STM_OFF_CMPA_HIGH    5'h14
`define STM_OFF_FLAGS        5'h18

// ************************************************************
// Field positions
// ************************************************************
`define STM_C0_PAUSE_BIT     7
`define STM_C0_CLKSEL_HI     6
`define STM_C0_CLKSEL_LO     4
`define STM_C0_ON_BIT        3
`define STM_C0_PERIOD_HI     2
`define STM_C0_PERIOD_LO     0
`define STM_C1_MODE_HI       7
`define STM_C1_MODE_LO       6
`define STM_C1_PINF_HI       5
`define STM_C1_PINF_LO       4
`define STM_C1_INIT_BIT      3
`define STM_C1_INV_BIT       2
`define STM_C1_SWAP_BIT      1
`define STM_C1_CLR_BIT       0
`define STM_FLAG_A_BIT       0
`define STM_FLAG_P_BIT       1

// ************************************************************
// Reset values and counts
// ************************************************************
`define STM_CONTROL_RESET    8'h00
`define STM_COUNT_MAX        10'h3FF
`define STM_HIGH_DIV         16
`define STM_HIGH_DIV_SLOW    64

`endif

// File: logic/stm_pkg.sv
// Types shared by the standard timer
package stm_pkg;

  typedef enum logic [1:0] {
    STM_MODE_COMPARE,
    STM_MODE_CAPTURE,
    STM_MODE_PWM,
    STM_MODE_TIMER
  } stm_mode_type;

  typedef enum logic [1:0] {
    STM_BUS_IDLE,
    STM_BUS_DONE
  } stm_bus_type;

  typedef struct packed {
    logic [7:0]  control0;
    logic [7:0]  control1;
    logic [9:0]  count;
    logic [9:0]  cmpa;
    logic [9:0]  capture;
    logic [7:0]  lowbuf;
    logic        flag_a;
    logic        flag_p;
    logic        capture_flag;
    logic        out_lvl;
    logic        on_prev;
    logic [1:0]  div4;
    logic [5:0]  divh;
    logic [2:0]  ext_sync;
    logic [2:0]  cap_sync;
    logic        sub_prev;
    logic        sub_sync;
    logic        high_prev;
    logic        high_sync;
    logic        pulse_armed;
    stm_bus_type bus;
    logic [31:0] rdata;
    logic        pin;
    logic        pin_n;
  } stm_state_type;

endpackage

// File: logic/stm_timer.sv
// Ten-bit standard timer with compare A and period P, Avalon-MM slave
// Operation
// - Ten-bit up-counter driven by the selected clock source.
// - Period comparator checks three bits against counter bits 9..7.
// - Compare A checks all ten counter bits.
// - Counter only changed by software through on-bit rising edge: clears.
// - Counter self-clears on overflow or selected match, raising flags.
// - Pause bit holds counter; clearing it resumes from held value.
// - Clock select picks sys/4, sys, high/16, high/64, sub, pin edges.
// - On bit cleared stops counter and keeps its value.
// - On-bit rising edge returns output to initial level in output modes.
// - Period match is code times 128; code zero means 1024.
// - Mode field: compare, capture, PWM/single-pulse, timer.
// - Timer mode: output controls have no effect, pin function unused.
// - Compare mode A match: none, low, high, toggle.
// - Compare mode low/high requests change pin only when they differ from initial; toggle always changes it.
// - PWM mode pin function: inactive, active, PWM, single pulse.
// - Capture mode trigger: rising, falling, both, disabled.
// - Initial-level bit: initial level, PWM polarity, single-pulse start.
// - Invert bit inverts output pin.
// - Swap bit exchanges period and duty comparators in PWM.
// - Clear select: A match, or P match / overflow when code zero.
// - Clear select ignored in PWM, single-pulse and capture modes.
// - Low bytes pass through a shared buffer latched on high access.
// - With clear select set in compare or timer mode, only the A flag is raised.
//
// The placing of the registers and the Avalon-MM interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "stm_defines.svh"

module stm_timer
  import stm_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        rst,
  input  wire logic [4:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output var  logic [31:0] avs_readdata,
  output var  logic        avs_waitrequest,
  input  wire logic        high_clock,
  input  wire logic        sub_clock,
  input  wire logic        ext_clock_pin,
  input  wire logic        capture_input_pin,
  output var  logic        timer_output_pin,
  output var  logic        timer_output_pin_inverted
);

  stm_state_type s_q;
  stm_state_type s_d;

  function automatic logic [9:0] stm_join(input logic [1:0] hi,
                                          input logic [7:0] lo);
    stm_join = {hi, lo};
  endfunction

  function automatic logic stm_agree_edge(input logic [2:0] sy,
                                          input logic rising);
    stm_agree_edge = (sy[2] != sy[1]) && (sy[1] == rising);
  endfunction

  // ************************************************************
  // Decoded controls
  // ************************************************************
  logic       pause_ctl;
  logic [2:0] clock_select;
  logic       counter_on;
  logic [2:0] period_code;
  logic [1:0] pin_function_sel;
  logic       out_init_level;
  logic       out_invert;
  logic       duty_period_swap;
  logic       clear_select;
  stm_mode_type mode;

  assign pause_ctl        = s_q.control0[`STM_C0_PAUSE_BIT];
  assign clock_select     = s_q.control0[`STM_C0_CLKSEL_HI:`STM_C0_CLKSEL_LO];
  assign counter_on       = s_q.control0[`STM_C0_ON_BIT];
  assign period_code      = s_q.control0[`STM_C0_PERIOD_HI:`STM_C0_PERIOD_LO];
  assign mode             = stm_mode_type'(
                              s_q.control1[`STM_C1_MODE_HI:`STM_C1_MODE_LO]);
  assign pin_function_sel = s_q.control1[`STM_C1_PINF_HI:`STM_C1_PINF_LO];
  assign out_init_level   = s_q.control1[`STM_C1_INIT_BIT];
  assign out_invert       = s_q.control1[`STM_C1_INV_BIT];
  assign duty_period_swap = s_q.control1[`STM_C1_SWAP_BIT];
  assign clear_select     = s_q.control1[`STM_C1_CLR_BIT];

  logic       tick;
  logic [9:0] count_nx;
  logic       match_a;
  logic       match_p;
  logic       overflow;
  logic       on_rise;
  logic       ext_rise;
  logic       ext_fall;
  logic       cap_rise;
  logic       cap_fall;
  logic       bus_req;
  logic       is_output_mode;

  always_comb begin
    ext_rise = stm_agree_edge(s_q.ext_sync, 1'b1);
    ext_fall = stm_agree_edge(s_q.ext_sync, 1'b0);
    cap_rise = stm_agree_edge(s_q.cap_sync, 1'b1);
    cap_fall = stm_agree_edge(s_q.cap_sync, 1'b0);
    // Clock source mux
    case (clock_select)
      3'h0:    tick = (s_q.div4 == 2'h3);
      3'h1:    tick = 1'b1;
      3'h2:    tick = s_q.high_sync & ~s_q.high_prev &
                      (s_q.divh[3:0] == 4'(`STM_HIGH_DIV - 1));
      3'h3:    tick = s_q.high_sync & ~s_q.high_prev &
                      (s_q.divh == 6'(`STM_HIGH_DIV_SLOW - 1));
      3'h4,
      3'h5:    tick = s_q.sub_sync & ~s_q.sub_prev;
      3'h6:    tick = ext_rise;
      default: tick = ext_fall;
    endcase
    // Judge the value the count edge would load, so the period is
    // exactly the compare value and not one clock longer
    count_nx = s_q.count + 10'h001;
    match_a  = tick && (count_nx == s_q.cmpa);
    match_p  = tick && (period_code != 3'h0) &&
               (count_nx[9:7] == period_code) && (count_nx[6:0] == 7'h00);
    overflow = tick && (s_q.count == `STM_COUNT_MAX);
    on_rise  = counter_on & ~s_q.on_prev;
    bus_req  = (avs_read | avs_write) && (s_q.bus == STM_BUS_IDLE);
    is_output_mode = (mode != STM_MODE_CAPTURE) && (mode != STM_MODE_TIMER);
  end

  // ************************************************************
  // Next-state logic
  // ************************************************************
  logic        run;
  logic        clr;
  logic        dmatch;
  logic        pmatch;
  logic [9:0]  p_end;
  logic        active;
  logic        set_a;
  logic        set_p;
  logic        set_c;

  always_comb begin
    s_d = s_q;
    run = counter_on & ~pause_ctl;
    clr = 1'b0;
    p_end = {period_code, 7'h00};
    active = 1'b0;
    pmatch = 1'b0;
    set_a = 1'b0;
    set_p = 1'b0;
    set_c = 1'b0;

    s_d.ext_sync  = {s_q.ext_sync[1:0], ext_clock_pin};
    s_d.cap_sync  = {s_q.cap_sync[1:0], capture_input_pin};
    s_d.high_sync = high_clock;
    s_d.high_prev = s_q.high_sync;
    s_d.sub_sync  = sub_clock;
    s_d.sub_prev  = s_q.sub_sync;
    s_d.on_prev   = counter_on;
    s_d.div4      = s_q.div4 + 2'h1;
    if (s_q.high_sync && !s_q.high_prev) begin
      s_d.divh = s_q.divh + 6'h01;
    end

    if (run && tick) begin
      s_d.count = s_q.count + 10'h001;
      if (mode == STM_MODE_PWM) begin
        // Period comparator clears, duty comparator sets edge
        pmatch = duty_period_swap ? match_a
                                  : (period_code == 3'h0 ? overflow
                                                         : match_p);
        clr = pmatch;
      end else if (mode == STM_MODE_CAPTURE) begin
        clr = overflow;
      end else if (clear_select) begin
        clr = match_a | overflow;
      end else begin
        clr = (period_code == 3'h0) ? overflow : match_p;
      end
      if (clr) begin
        s_d.count = 10'h000;
      end
      // Flags, set wins over a software clear below
      if (match_a && s_q.cmpa != 10'h000) begin
        set_a      = 1'b1;
        s_d.flag_a = 1'b1;
      end
      if ((match_p || (period_code == 3'h0 && overflow)) &&
          !(clear_select && mode != STM_MODE_PWM &&
            mode != STM_MODE_CAPTURE)) begin
        set_p      = 1'b1;
        s_d.flag_p = 1'b1;
      end
      // Compare-mode pin action
      if (mode == STM_MODE_COMPARE && match_a && s_q.cmpa != 10'h000) begin
        case (pin_function_sel)
          2'h1:    if (out_init_level) s_d.out_lvl = 1'b0;
          2'h2:    if (!out_init_level) s_d.out_lvl = 1'b1;
          2'h3:    s_d.out_lvl = ~s_q.out_lvl;
          default: s_d.out_lvl = s_q.out_lvl;
        endcase
      end
      if (mode == STM_MODE_PWM && pin_function_sel == 2'h3 && match_a) begin
        s_d.pulse_armed = 1'b0;
      end
    end

    // Capture of count on selected edge
    if (mode == STM_MODE_CAPTURE && counter_on) begin
      case (pin_function_sel)
        2'h0:    active = cap_rise;
        2'h1:    active = cap_fall;
        2'h2:    active = cap_rise | cap_fall;
        default: active = 1'b0;
      endcase
      if (active) begin
        s_d.capture      = s_q.count;
        set_c            = 1'b1;
        s_d.capture_flag = 1'b1;
      end
    end

    if (on_rise) begin
      s_d.count       = 10'h000;
      s_d.out_lvl     = out_init_level;
      s_d.pulse_armed = 1'b1;
    end

    // Duty compare in PWM
    dmatch = duty_period_swap
             ? ((period_code == 3'h0) ? 1'b1 : (s_q.count < p_end))
             : (s_q.count < s_q.cmpa);
    active = 1'b0;
    if (mode == STM_MODE_PWM) begin
      case (pin_function_sel)
        2'h0:    active = 1'b0;
        2'h1:    active = 1'b1;
        2'h2:    active = counter_on & dmatch;
        default: active = counter_on & s_q.pulse_armed;
      endcase
    end
    if (mode == STM_MODE_TIMER) begin
      s_d.pin = 1'b0;
    end else if (mode == STM_MODE_PWM) begin
      s_d.pin = (active ~^ out_init_level) ^ out_invert;
    end else begin
      s_d.pin = s_q.out_lvl ^ out_invert;
    end
    s_d.pin_n = ~s_d.pin;

    // ************************************************************
    // Avalon-MM slave: one wait cycle, then answer
    // ************************************************************
    s_d.bus = STM_BUS_IDLE;
    if (bus_req) begin
      s_d.bus   = STM_BUS_DONE;
      s_d.rdata = 32'h0000_0000;
      if (avs_write) begin
        case (avs_address)
          `STM_OFF_CONTROL0: s_d.control0 = avs_writedata[7:0];
          `STM_OFF_CONTROL1: s_d.control1 = avs_writedata[7:0];
          `STM_OFF_CMPA_LOW: s_d.lowbuf = avs_writedata[7:0];
          `STM_OFF_CMPA_HIGH: s_d.cmpa =
            stm_join(avs_writedata[1:0], s_q.lowbuf);
          `STM_OFF_FLAGS: begin
            // Write one to clear; a same-cycle set wins
            if (avs_writedata[`STM_FLAG_A_BIT] && !set_a)
              s_d.flag_a = 1'b0;
            if (avs_writedata[`STM_FLAG_P_BIT] && !set_p)
              s_d.flag_p = 1'b0;
            if (avs_writedata[2] && !set_c)
              s_d.capture_flag = 1'b0;
          end
          default: s_d.rdata = 32'h0000_0000;
        endcase
      end else begin
        case (avs_address)
          `STM_OFF_CONTROL0:   s_d.rdata = {24'h0, s_q.control0};
          `STM_OFF_CONTROL1:   s_d.rdata = {24'h0, s_q.control1};
          `STM_OFF_COUNT_LOW,
          `STM_OFF_CMPA_LOW:   s_d.rdata = {24'h0, s_q.lowbuf};
          `STM_OFF_COUNT_HIGH: begin
            // Capture mode shows the captured value instead
            if (mode == STM_MODE_CAPTURE) begin
              s_d.rdata  = {30'h0, s_q.capture[9:8]};
              s_d.lowbuf = s_q.capture[7:0];
            end else begin
              s_d.rdata  = {30'h0, s_q.count[9:8]};
              s_d.lowbuf = s_q.count[7:0];
            end
          end
          `STM_OFF_CMPA_HIGH: begin
            s_d.rdata  = {30'h0, s_q.cmpa[9:8]};
            s_d.lowbuf = s_q.cmpa[7:0];
          end
          `STM_OFF_FLAGS:
            s_d.rdata = {29'h0, s_q.capture_flag, s_q.flag_p, s_q.flag_a};
          default: s_d.rdata = 32'h0000_0000;
        endcase
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      s_q <= '0;
      s_q.pin_n <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  assign avs_readdata              = s_q.rdata;
  assign avs_waitrequest           = (avs_read | avs_write) &&
                                     (s_q.bus == STM_BUS_IDLE);
  assign timer_output_pin          = s_q.pin;
  assign timer_output_pin_inverted = s_q.pin_n;

  // ************************************************************
  // Checks
  // ************************************************************
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  on_clears_count_a: assert property (
    on_rise |=> s_q.count == 10'h000)
    else $error("count not cleared on switch-on");
  off_holds_a: assert property (
    !counter_on && !on_rise |=> $stable(s_q.count))
    else $error("count moved while off");
  pause_holds_a: assert property (
    pause_ctl && !on_rise |=> $stable(s_q.count))
    else $error("count moved while paused");
  init_level_a: assert property (
    on_rise && mode == STM_MODE_COMPARE
    |=> s_q.out_lvl == $past(out_init_level))
    else $error("output not reset to initial level");
  p_flag_block_a: assert property (
    clear_select && mode == STM_MODE_COMPARE && !s_q.flag_p
    |=> !s_q.flag_p)
    else $error("P flag raised with clear select");
  step_one_a: assert property (
    run && tick && !clr && !on_rise
    |=> s_q.count == $past(s_q.count) + 10'h001)
    else $error("counter did not step by one");
  p_clear_a: assert property (
    run && match_p && !clear_select && mode == STM_MODE_COMPARE && !on_rise
    |=> s_q.count == 10'h000)
    else $error("period match did not clear");
  pins_pair_a: assert property (
    ##1 timer_output_pin != timer_output_pin_inverted)
    else $error("output pins not complementary");
  cmpa_latch_a: assert property (
    bus_req && avs_write && avs_address == `STM_OFF_CMPA_HIGH
    |=> s_q.cmpa[7:0] == $past(s_q.lowbuf))
    else $error("low byte not latched from buffer");
  wait_bound_a: assert property (avs_read |-> ##[0:1] !avs_waitrequest)
    else $error("bus answer too slow");

  cov_on_c: cover property (on_rise);
  cov_match_c: cover property (match_a && run);
  cov_pwm_c: cover property (mode == STM_MODE_PWM && $rose(timer_output_pin));
  cov_capture_c: cover property ($rose(s_q.capture_flag));

endmodule  // stm_timer
`default_nettype wire

// File: verification/stm_pins_model.sv
// Pin-side partner: slow clocks, external count pin and capture pin
`timescale 1ns/1ps
`default_nettype none

module stm_pins_model (
  input  wire logic core_clk,
  output var  logic high_clock,
  output var  logic sub_clock,
  output var  logic ext_clock_pin,
  output var  logic capture_input_pin
);
  logic [3:0] div_q = 4'h0;

  // ************************************************************
  // Free-running slow clocks
  // ************************************************************
  always @(posedge core_clk) begin
    div_q <= div_q + 4'h1;
  end
  assign high_clock = div_q[0];
  assign sub_clock  = div_q[3];

  // ************************************************************
  // Pin stimulus, each level held past the 3-flop synchroniser
  // ************************************************************
  initial begin
    ext_clock_pin     = 1'b0;
    capture_input_pin = 1'b0;
  end

  // Count pin idles low between bursts
  task automatic ext_pulses(input int n);
    repeat (n) begin
      repeat (4) @(posedge core_clk);
      ext_clock_pin <= 1'b1;
      repeat (6) @(posedge core_clk);
      ext_clock_pin <= 1'b0;
    end
    repeat (6) @(posedge core_clk);
  endtask

  task automatic cap_edge(input logic lvl);
    @(posedge core_clk);
    capture_input_pin <= lvl;
    repeat (6) @(posedge core_clk);
  endtask
endmodule // stm_pins_model

`default_nettype wire

// File: verification/tb.sv
// Self-checking testbench for the standard timer
`timescale 1ns/1ps
`default_nettype none
`include "stm_defines.svh"

module tb;
  localparam logic [4:0] A_C0 = 5'(`STM_OFF_CONTROL0);
  localparam logic [4:0] A_C1 = 5'(`STM_OFF_CONTROL1);
  localparam logic [4:0] A_CL = 5'(`STM_OFF_COUNT_LOW);
  localparam logic [4:0] A_CH = 5'(`STM_OFF_COUNT_HIGH);
  localparam logic [4:0] A_AL = `STM_OFF_CMPA_LOW;
  localparam logic [4:0] A_AH = `STM_OFF_CMPA_HIGH;
  localparam logic [4:0] A_FL = `STM_OFF_FLAGS;

  logic        core_clk;
  logic        rst;
  logic [4:0]  avs_address;
  logic        avs_read;
  logic        avs_write;
  logic [31:0] avs_writedata;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        high_clock, sub_clock, ext_clock_pin, capture_input_pin;
  logic        timer_output_pin, timer_output_pin_inverted;
  int          n_fail = 0;
  int          compares = 0;
  int          cycles = 0;

  always #50 core_clk = ~core_clk;

  stm_timer dut (.core_clk(core_clk), .rst(rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .high_clock(high_clock),
    .sub_clock(sub_clock), .ext_clock_pin(ext_clock_pin),
    .capture_input_pin(capture_input_pin),
    .timer_output_pin(timer_output_pin),
    .timer_output_pin_inverted(timer_output_pin_inverted));

  stm_pins_model pins (.core_clk(core_clk), .high_clock(high_clock),
    .sub_clock(sub_clock), .ext_clock_pin(ext_clock_pin),
    .capture_input_pin(capture_input_pin));

  // ************************************************************
  // Shared helpers
  // ************************************************************
  task automatic end_sim;
    $display("checks %0d, mismatches %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 30000) begin
      n_fail++;
      end_sim;
    end
  end

  task automatic chk(input string nm, input logic [9:0] e, input logic [9:0] g);
    compares++;
    if (g !== e) begin
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
      n_fail++;
    end
  endtask

  // Request held until a rising edge sees waitrequest low; data taken
  // there, released there, then one idle edge; only the bench limit
  // ends a wait
  task automatic bus(input logic we, input logic [4:0] a, input logic [7:0] d,
                     output logic [7:0] r);
    avs_address   <= a;
    avs_writedata <= {24'h000000, d};
    avs_write     <= we;
    avs_read      <= ~we;
    do begin
      @(posedge core_clk);
    end while (avs_waitrequest !== 1'b0);
    r = avs_readdata[7:0];
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
    @(posedge core_clk);
  endtask

  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    logic [7:0] r;
    bus(1'b1, a, d, r);
  endtask

  task automatic rd(input logic [4:0] a, output logic [7:0] r);
    bus(1'b0, a, 8'h00, r);
  endtask

  // High byte first so the low byte comes from the shared buffer
  task automatic rd_pair(input logic [4:0] hi_a, output logic [9:0] v);
    logic [7:0] hi;
    logic [7:0] lo;
    rd(hi_a, hi);
    rd(hi_a - 5'h04, lo);
    v = {hi[1:0], lo};
  endtask

  task automatic pin_chk(input string nm, input logic e);
    @(negedge core_clk);
    chk(nm, {9'h000, e}, {9'h000, timer_output_pin});
    chk(nm, {9'h000, ~e}, {9'h000, timer_output_pin_inverted});
    @(posedge core_clk);
  endtask

  // Switched off before every mode or pin-function change
  task automatic setup(input logic [7:0] c1, input logic [7:0] c0);
    wr(A_C0, 8'h00);
    wr(A_C1, c1);
    wr(A_C0, c0);
  endtask

  // ************************************************************
  // Scenarios
  // ************************************************************
  task automatic t_reset;
    logic [7:0] r;
    rd(A_C0, r);
    chk("control0 reset", 10'h000, {2'b00, r});
    rd(A_C1, r);
    chk("control1 reset", 10'h000, {2'b00, r});
    rd(5'h1C, r);
    chk("unmapped read", 10'h000, {2'b00, r});
    $display("reset test done");
  endtask

  task automatic t_hold;
    logic [9:0] v1, v2, v3, v4;
    wr(A_C0, 8'h98);
    rd_pair(A_CH, v1);
    chk("clear on switch-on", 10'h000, v1);
    wr(A_C0, 8'h18);
    repeat (10) @(posedge core_clk);
    wr(A_C0, 8'h98);
    rd_pair(A_CH, v1);
    repeat (20) @(posedge core_clk);
    rd_pair(A_CH, v2);
    chk("paused count held", v1, v2);
    chk("count advanced", 10'h001, {9'h000, v1 != 10'h000});
    wr(A_C0, 8'h18);
    wr(A_C0, 8'h10);
    rd_pair(A_CH, v3);
    repeat (20) @(posedge core_clk);
    rd_pair(A_CH, v4);
    chk("off count held", v3, v4);
    chk("resumed from held", 10'h001, {9'h000, v3 > v1});
    $display("pause and off test done");
  endtask

  task automatic t_ext;
    logic [9:0] v;
    for (int s = 6; s < 8; s++) begin
      setup(8'h00, {1'b0, 3'(s), 4'h8});
      pins.ext_pulses(7);
      rd_pair(A_CH, v);
      chk("pin edge count", 10'h007, v);
    end
    $display("external clock test done");
  endtask

  // 384 counted edges: every internal rate divides it exactly
  task automatic t_clk;
    logic [9:0] v;
    logic [9:0] want [6];
    want = '{10'h060, 10'h180, 10'h00C, 10'h003, 10'h018, 10'h018};
    for (int s = 0; s < 6; s++) begin
      setup(8'h00, {1'b0, 3'(s), 4'h8});
      repeat (382) @(posedge core_clk);
      wr(A_C0, {1'b1, 3'(s), 4'h8});
      rd_pair(A_CH, v);
      chk("clock source count", want[s], v);
    end
    $display("clock source test done");
  endtask

  task automatic t_cmp;
    logic [9:0] v;
    logic [7:0] r;
    logic [3:0] lvl;
    lvl = 4'b1100;
    wr(A_C0, 8'h00);
    wr(A_AL, 8'h05);
    wr(A_AH, 8'h00);
    rd_pair(A_AH, v);
    chk("compare A readback", 10'h005, v);
    wr(A_FL, 8'h07);
    for (int f = 0; f < 4; f++) begin
      setup({2'b00, 2'(f), 4'b0001}, 8'h68);
      pin_chk("initial level", 1'b0);
      pins.ext_pulses(4);
      pin_chk("before match", 1'b0);
      pins.ext_pulses(1);
      pin_chk("match action", lvl[f]);
      rd_pair(A_CH, v);
      chk("cleared by A", 10'h000, v);
    end
    rd(A_FL, r);
    chk("only A flag", 10'h001, {8'h00, r[1:0]});
    setup(8'h2D, 8'h68);
    pin_chk("inverted initial", 1'b0);
    pins.ext_pulses(5);
    pin_chk("request equals initial", 1'b0);
    $display("compare output test done");
  endtask

  task automatic t_period;
    logic [9:0] v;
    logic [7:0] r;
    setup(8'h00, 8'h00);
    wr(A_FL, 8'h07);
    wr(A_C0, 8'h69);
    pins.ext_pulses(127);
    rd(A_FL, r);
    chk("no P flag at 127", 10'h000, {9'h000, r[1]});
    pins.ext_pulses(1);
    rd(A_FL, r);
    chk("P flag at 128", 10'h001, {9'h000, r[1]});
    rd_pair(A_CH, v);
    chk("cleared by P", 10'h000, v);
    $display("period test done");
  endtask

  task automatic t_pwm;
    logic [7:0] c1 [3];
    logic [2:0] e;
    c1 = '{8'h88, 8'h98, 8'h90};
    e  = 3'b010;
    for (int i = 0; i < 3; i++) begin
      setup(c1[i], 8'h68);
      repeat (4) @(posedge core_clk);
      pin_chk("forced pwm level", e[i]);
    end
    setup(8'hC8, 8'h68);
    pin_chk("timer mode pin", 1'b0);
    $display("pwm forced level test done");
  endtask

  task automatic t_capture;
    logic [9:0] v;
    logic [7:0] r;
    setup(8'h40, 8'h68);
    wr(A_FL, 8'h07);
    pins.ext_pulses(3);
    pins.cap_edge(1'b1);
    rd_pair(A_CH, v);
    chk("captured count", 10'h003, v);
    rd(A_FL, r);
    chk("capture flag", 10'h001, {9'h000, r[2]});
    $display("capture test done");
  endtask

  initial begin
    core_clk      = 1'b0;
    rst           = 1'b1;
    avs_address   = 5'h00;
    avs_read      = 1'b0;
    avs_write     = 1'b0;
    avs_writedata = 32'h0000_0000;
    repeat (2) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    t_reset;
    t_hold;
    t_ext;
    t_clk;
    t_cmp;
    t_period;
    t_pwm;
    t_capture;
    end_sim;
  end
endmodule // tb

`default_nettype wire
